// ---- sdid_core.sv ----
// serial input decoder: frame capture, word apply, mode and switch drive
//
// Behaviour
// - A 24-bit shift register takes the data line on each of the first 24 falling serial clock edges of a frame.
// - Frame select is active low and enables shifting while it is held low.
// - After the 24th falling edge of a frame the word is applied to code and mode.
// - Frame select rising before the 24th edge discards the partial word unchanged.
// - Reset loads zero-scale or midscale code, chosen by a strap input.
// - The four top code bits decode into 15 thermometer segment switch controls.
// - The 12 low code bits drive the 12 ladder switch controls directly.
// - The code is straight binary, zero lowest and all ones full scale.
// - Word bits 17 and 16 select normal or one of three power-down modes.
// - A power-down word still loads its own 16 code bits as the stored code.
// - An all-ones word starts a software reset that an abort cannot cancel.
`timescale 1ns/10ps
module sdid_core
    import sdid_pkg::*;
#(
    parameter int unsigned SYNC_STAGES = 3
) (
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire sdid_pkg::sdid_pins_t   pins,
    input  wire logic                   midscale_strap,
    output sdid_pkg::sdid_drive_t       drive,
    output logic [15:0]                 code,
    output logic                        word_applied,
    output logic                        frame_aborted
);
    import sdid_pkg::*;

    initial begin
        if (SYNC_STAGES != 3) begin
            $error("sdid_core: SYNC_STAGES must be 3");
        end
    end

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_SHIFT = 3'h2,
        ST_DONE  = 3'h4
    } sdid_state_t;

    // three-stage synchronisers; stage 0 is read only by stage 1
    logic [2:0] sel_sync_ff;
    logic [2:0] clk_sync_ff;
    logic [2:0] dat_sync_ff;
    logic       sel_q_ff;
    logic       clk_q_ff;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_sync_ff <= 3'h7;
            // serial clock idles high, so reset matches its idle level
            clk_sync_ff <= 3'h7;
            dat_sync_ff <= 3'h0;
        end else begin
            sel_sync_ff <= {sel_sync_ff[1:0], pins.frame_sel_n};
            clk_sync_ff <= {clk_sync_ff[1:0], pins.sclk};
            dat_sync_ff <= {dat_sync_ff[1:0], pins.sdata};
        end
    end

    // a change counts once stages 1 and 2 agree
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_q_ff <= 1'h1;
            clk_q_ff <= 1'h1;
        end else begin
            if (sel_sync_ff[1] == sel_sync_ff[2]) begin
                sel_q_ff <= sel_sync_ff[2];
            end
            if (clk_sync_ff[1] == clk_sync_ff[2]) begin
                clk_q_ff <= clk_sync_ff[2];
            end
        end
    end

    logic sel_low;
    logic sel_rise;
    logic sel_fall;
    logic sclk_fall;
    assign sel_low   = !sel_q_ff;
    assign sel_rise  = !sel_q_ff && (sel_sync_ff[1] == sel_sync_ff[2]) && sel_sync_ff[2];
    assign sel_fall  = sel_q_ff && (sel_sync_ff[1] == sel_sync_ff[2]) && !sel_sync_ff[2];
    assign sclk_fall = clk_q_ff && (clk_sync_ff[1] == clk_sync_ff[2]) && !clk_sync_ff[2];

    sdid_state_t state_ff;
    sdid_state_t nxt_state;
    logic [23:0] shift_ff;
    logic [23:0] nxt_shift;
    logic [4:0]  count_ff;
    logic        apply;
    logic        bit_take;

    // sample data with the edge that qualifies the clock fall
    assign bit_take = sclk_fall && sel_low && (state_ff == ST_SHIFT);
    assign nxt_shift = {shift_ff[22:0], dat_sync_ff[2]};
    assign apply    = bit_take && (count_ff == LAST_BIT_IDX);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:  if (sel_fall) nxt_state = ST_SHIFT;
            ST_SHIFT: begin
                if (apply) begin
                    nxt_state = ST_DONE;
                end else if (sel_rise) begin
                    nxt_state = ST_IDLE;
                end
            end
            // further clocks after the word are ignored until select rises
            ST_DONE:  if (sel_rise) nxt_state = ST_IDLE;
            default:  nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_ff <= 24'h000000;
            count_ff <= BIT_CNT_ZERO;
        end else if (state_ff != ST_SHIFT || sel_rise) begin
            shift_ff <= 24'h000000;
            count_ff <= BIT_CNT_ZERO;
        end else if (bit_take) begin
            shift_ff <= nxt_shift;
            count_ff <= count_ff + 5'h01;
        end
    end

    // power-on default is caught by a clocked step after reset release
    logic        init_done_ff;
    logic [15:0] code_ff;
    sdid_mode_t  mode_ff;
    logic        sw_reset;
    assign sw_reset = apply && (nxt_shift == WORD_SW_RESET);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            init_done_ff <= 1'h0;
        end else begin
            init_done_ff <= 1'h1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            code_ff <= CODE_ZERO;
            mode_ff <= SDID_MODE_NORMAL;
        end else if (!init_done_ff || sw_reset) begin
            // software reset is committed in one cycle, so no abort can reach it
            code_ff <= midscale_strap ? CODE_MID : CODE_ZERO;
            mode_ff <= SDID_MODE_NORMAL;
        end else if (apply) begin
            // mode bits never touch the code, but a power-down word still loads its own code bits
            code_ff <= nxt_shift[CODE_LSB +: CODE_BITS];
            mode_ff <= sdid_mode_t'(nxt_shift[MODE_LSB +: 2]);
        end
    end

    logic [14:0] seg_on;
    sdid_seg_decode #(
        .IN_BITS (SEG_MSBS)
    ) u_seg (
        .msbs   (code_ff[CODE_BITS-1 -: SEG_MSBS]),
        .seg_on (seg_on)
    );

    sdid_drive_t drive_ff;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            drive_ff <= '0;
        end else begin
            drive_ff.segment_switch_controls <= seg_on;
            drive_ff.ladder_switch_controls  <= code_ff[LADDER_BITS-1:0];
            drive_ff.power_mode_bit_high     <= mode_ff[1];
            drive_ff.power_mode_bit_low      <= mode_ff[0];
        end
    end

    logic applied_ff;
    logic aborted_ff;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            applied_ff <= 1'h0;
            aborted_ff <= 1'h0;
        end else begin
            applied_ff <= apply;
            aborted_ff <= (state_ff == ST_SHIFT) && sel_rise && !apply;
        end
    end

    assign drive         = drive_ff;
    assign code          = code_ff;
    assign word_applied  = applied_ff;
    assign frame_aborted = aborted_ff;

    sequence s_abort;
        (state_ff == ST_SHIFT) && sel_rise && !apply;
    endsequence

    chk_apply_loads_code: assert property (@(posedge clk) disable iff (!reset_n)
        apply && !sw_reset && init_done_ff |=> code_ff == $past(nxt_shift[15:0]))
        else $error("applied word did not reach the code");
    chk_abort_keeps_code: assert property (@(posedge clk) disable iff (!reset_n)
        s_abort and init_done_ff |=> $stable(code_ff) && $stable(mode_ff))
        else $error("abort changed code or mode");
    chk_abort_clears_word: assert property (@(posedge clk) disable iff (!reset_n)
        s_abort |=> count_ff == BIT_CNT_ZERO && state_ff == ST_IDLE)
        else $error("abort left a partial word");
    chk_shift_takes_bit: assert property (@(posedge clk) disable iff (!reset_n)
        bit_take && !sel_rise |=> shift_ff[0] == $past(dat_sync_ff[2]))
        else $error("falling edge bit not shifted in");
    chk_no_shift_idle: assert property (@(posedge clk) disable iff (!reset_n)
        state_ff == ST_IDLE |=> count_ff == BIT_CNT_ZERO)
        else $error("bits counted while frame select high");
    chk_soft_reset_code: assert property (@(posedge clk) disable iff (!reset_n)
        sw_reset |=> code_ff == (midscale_strap ? CODE_MID : CODE_ZERO)
                     && mode_ff == SDID_MODE_NORMAL)
        else $error("software reset did not restore code");
    chk_ladder_follows: assert property (@(posedge clk) disable iff (!reset_n)
        ##1 drive_ff.ladder_switch_controls == $past(code_ff[11:0]))
        else $error("ladder controls do not follow code");
    chk_segments_count: assert property (@(posedge clk) disable iff (!reset_n)
        ##1 $countones(drive_ff.segment_switch_controls) == $past(code_ff[15:12]))
        else $error("segment count does not match top bits");
    chk_segments_thermo: assert property (@(posedge clk) disable iff (!reset_n)
        (drive_ff.segment_switch_controls
         & (drive_ff.segment_switch_controls + 15'h0001)) == 15'h0000)
        else $error("segment controls are not a thermometer");
    chk_pd_keeps_code: assert property (@(posedge clk) disable iff (!reset_n)
        apply && !sw_reset && init_done_ff && nxt_shift[17:16] != 2'h0
        |=> ##1 drive_ff.ladder_switch_controls == $past(nxt_shift[11:0], 2))
        else $error("power-down lost the code");
endmodule

// ---- sdid_pkg.sv ----
// constants and carrier types shared by the serial converter input decoder
package sdid_pkg;
    localparam int unsigned WORD_BITS      = 24;
    localparam int unsigned CODE_BITS      = 16;
    localparam int unsigned SEG_MSBS       = 4;
    localparam int unsigned SEG_COUNT      = 15;
    localparam int unsigned LADDER_BITS    = 12;
    localparam int unsigned MODE_LSB       = 16;
    localparam int unsigned CODE_LSB       = 0;
    localparam int unsigned CLK_PERIOD_NS  = 8;
    localparam int unsigned SYNC_HIGH_NS   = 12;
    localparam int unsigned SYNC_HIGH_CYC  =
        (SYNC_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] CODE_ZERO      = 16'h0000;
    localparam logic [15:0] CODE_MID       = 16'h8000;
    localparam logic [23:0] WORD_SW_RESET  = 24'hFFFFFF;
    localparam logic [4:0]  LAST_BIT_IDX   = 5'h17;
    localparam logic [4:0]  BIT_CNT_ZERO   = 5'h00;

    typedef enum logic [1:0] {
        SDID_MODE_NORMAL = 2'h0,
        SDID_MODE_PD_HIZ = 2'h1,
        SDID_MODE_PD_100K = 2'h2,
        SDID_MODE_PD_1K  = 2'h3
    } sdid_mode_t;

    // pin group seen from the host side
    typedef struct packed {
        logic frame_sel_n;
        logic sclk;
        logic sdata;
    } sdid_pins_t;

    // converter switch drive
    typedef struct packed {
        logic [14:0] segment_switch_controls;
        logic [11:0] ladder_switch_controls;
        logic        power_mode_bit_high;
        logic        power_mode_bit_low;
    } sdid_drive_t;
endpackage

// ---- sdid_seg_decode.sv ----
// thermometer decoder for the top code bits onto the segment switches
`timescale 1ns/10ps
module sdid_seg_decode #(
    parameter int unsigned IN_BITS = 4
) (
    input  wire logic [IN_BITS-1:0]         msbs,
    output logic      [(1<<IN_BITS)-2:0]    seg_on
);
    initial begin
        if (IN_BITS < 1 || IN_BITS > 8) begin
            $error("sdid_seg_decode: IN_BITS out of range");
        end
    end

    // switch k goes to the reference when the code exceeds k
    always_comb begin
        for (int k = 0; k < (1 << IN_BITS) - 1; k++) begin
            seg_on[k] = (32'(msbs) > k);
        end
    end
endmodule

// ---- sdid_host.sv ----
// host-side serial port model driving frame select, clock and data
`timescale 1ns/10ps
module sdid_host
    import sdid_pkg::*;
(
    input  wire logic           clk,
    output sdid_pkg::sdid_pins_t pins
);
    initial begin
        pins = 3'b110;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    // fewer than 24 bits makes an aborted frame, more gives ignored extra clocks
    task automatic send(input logic [23:0] w, input int n);
        pins.frame_sel_n = 1'b0;
        idle(5);
        for (int i = 0; i < n; i++) begin
            pins.sdata = (i < 24) ? w[23-i] : 1'b0;
            idle(5);
            pins.sclk = 1'b0;
            idle(5);
            pins.sclk = 1'b1;
        end
        idle(2);
        pins.frame_sel_n = 1'b1;
        // released data line shows no stale bit
        pins.sdata = ~pins.sdata;
        idle(6);
    endtask
endmodule

// ---- sdid_core_bench.sv ----
// self-checking bench for the serial converter input decoder
`timescale 1ns/10ps
module sdid_core_bench;
    import sdid_pkg::*;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        midscale_strap = 1'b1;
    sdid_pins_t  pins;
    sdid_drive_t drive;
    logic [15:0] code;
    logic        word_applied;
    logic        frame_aborted;
    logic [15:0] exp_code;
    logic [1:0]  exp_mode;
    logic [31:0] r;
    int          errors = 0;
    int          comparisons = 0;
    int          n_app = 0;
    int          n_abt = 0;

    always #4 clk = ~clk;

    sdid_host host (.clk(clk), .pins(pins));
    sdid_core #(.SYNC_STAGES(3)) DUT (.clk(clk), .reset_n(reset_n), .pins(pins),
        .midscale_strap(midscale_strap), .drive(drive), .code(code),
        .word_applied(word_applied), .frame_aborted(frame_aborted));

    always @(posedge clk) begin
        if (word_applied === 1'b1) n_app++;
        if (frame_aborted === 1'b1) n_abt++;
    end

    function automatic logic [14:0] therm(input logic [3:0] m);
        for (int i = 0; i < 15; i++) therm[i] = (m > i);
    endfunction

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic check_state();
        check("code", {16'h0, exp_code}, {16'h0, code});
        check("seg", {17'h0, therm(exp_code[15:12])}, {17'h0, drive.segment_switch_controls});
        check("ladder", {20'h0, exp_code[11:0]}, {20'h0, drive.ladder_switch_controls});
        check("mode", {30'h0, exp_mode},
            {30'h0, drive.power_mode_bit_high, drive.power_mode_bit_low});
    endtask

    task automatic do_reset(input logic strap);
        @(negedge clk);
        reset_n = 1'b0;
        midscale_strap = strap;
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        exp_code = strap ? CODE_MID : CODE_ZERO;
        exp_mode = 2'h0;
        check_state();
    endtask

    task automatic write(input logic [23:0] wd, input int n);
        int a0;
        int b0;
        a0 = n_app;
        b0 = n_abt;
        host.send(wd, n);
        repeat (6) @(negedge clk);
        // clocks past the 24th are ignored, so longer frames apply the first 24 bits
        if (n >= 24 && wd === WORD_SW_RESET) begin
            exp_code = midscale_strap ? CODE_MID : CODE_ZERO;
            exp_mode = 2'h0;
        end else if (n >= 24) begin
            exp_code = wd[15:0];
            exp_mode = wd[17:16];
        end
        check("applied", n >= 24, n_app - a0);
        check("aborted", n < 24, n_abt - b0);
        check_state();
    endtask

    task automatic end_of_test();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // about 55 frames of up to about 280 cycles each, with ample margin
    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'h5031));
        do_reset(1'b1);
        do_reset(1'b0);
        for (int m = 0; m < 4; m++) begin
            write({6'h00, m[1:0], 16'h0000}, 24);
            write({6'h00, m[1:0], 16'hFFFF}, 24);
        end
        write(24'h00FFFF, 24);
        write(24'hFFFFFF, 1);
        write(24'hFFFFFF, 23);
        write(24'h012345, 26);
        for (int k = 0; k < 10; k++) begin
            r = $urandom;
            write({r[29:24], 2'h0, r[15:0]}, 24);
            write({r[29:24], r[17:16], r[15:0]}, 24);
            write({r[29:24], 2'h0, r[15:0]}, 24);
            write({1'b0, r[31:9]}, 1 + r[7:0] % 23);
        end
        write(24'h03ABCD, 24);
        @(negedge clk);
        midscale_strap = 1'b1;
        write(WORD_SW_RESET, 24);
        end_of_test();
    end
endmodule
